// >>> core/tcw_map.svh
`ifndef TCW_MAP_SVH
`define TCW_MAP_SVH

// counter and capture width
`define TCW_CNT_W 16
`define TCW_CNT_ZERO 16'h0000
`define TCW_CNT_ONE 16'h0001

// start control field codes
`define TCW_START_STOP 2'b00
`define TCW_START_CMD 2'b01
`define TCW_START_RISE 2'b10
`define TCW_START_FALL 2'b11

// source clock select codes
`define TCW_SRC_SLOW 2'b00
`define TCW_SRC_MID 2'b01
`define TCW_SRC_FAST 2'b10
`define TCW_SRC_FULL 2'b11

// prescaler width and the low-bit masks for each source rate
`define TCW_PRE_W 12
`define TCW_PRE_ZERO 12'h000
`define TCW_PRE_ONE 12'h001
`define TCW_MASK_SLOW 12'h7FF
`define TCW_MASK_MID 12'h07F
`define TCW_MASK_FAST 12'h007
`define TCW_MASK_FULL 12'h000

`endif

// >>> core/tcw_pkg.sv
package tcw_pkg;

  // operating modes covered by this block
  typedef enum logic [1:0] {
    TCW_EVENT = 2'b00,
    TCW_WINDOW = 2'b01,
    TCW_PULSE = 2'b10,
    TCW_IDLE = 2'b11
  } tcw_mode_e;

  // pulse width measurement phase
  typedef enum logic {
    TCW_WAIT = 1'b0,
    TCW_RUN = 1'b1
  } tcw_phase_e;

endpackage : tcw_pkg

// >>> core/tcw_timer1.sv
// How it works
// RULE1: event mode counts each selected edge of the input pin.
// RULE2: event mode match on compare_a raises interrupt and clears the counter.
// RULE3: event mode compare is checked on the edge opposite the counting edge.
// RULE4: source holds each pin level at least two machine cycles.
// RULE5: auto-capture copies the running count into capture_b on each source tick.
// RULE6: software waits one source tick before first auto-captured read.
// RULE7: software reads auto-capture only while running and capture enabled.
// RULE8: window mode counts source ticks gated by window; match interrupts and clears.
// RULE9: window polarity selects counting while pin high or while pin low.
// RULE10: window pulse is much slower than the selected source clock.
// RULE11: pulse mode starts on trigger edge, then counts source ticks.
// RULE12: capture_edge_mode one selects single-edge, zero selects double-edge capture.
// RULE13: single-edge: opposite edge captures, interrupts, sets counter to one; waits for next trigger.
// RULE14: double-edge: capture on opposite and trigger edges; trigger also clears.
// RULE15: single-edge: after capture counter holds at one until next trigger.
// RULE16: software reads capture_b before next trigger edge, in one access.
// RULE17: software discards the first captured value after start.
// RULE18: software picks rising trigger for high widths, falling for low.
// RULE19: stop power mode entry clears start field to stop and halts counter.
// RULE20: counter, compare_a and capture_b are 16 bits; capture moves whole value.
`timescale 1ns/1ns
`include "tcw_map.svh"

module tcw_timer1 (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_enable,
  input wire logic event_input_pin,
  input wire tcw_pkg::tcw_mode_e mode,
  input wire logic [1:0] source_clock_select,
  input wire logic window_polarity,
  input wire logic capture_edge_mode,
  input wire logic auto_capture_en,
  input wire logic [`TCW_CNT_W-1:0] compare_a,
  input wire logic start_write,
  input wire logic [1:0] start_wdata,
  input wire logic stop_mode_enter,
  output logic [1:0] start_edge_select,
  output logic [`TCW_CNT_W-1:0] count,
  output logic [`TCW_CNT_W-1:0] capture_b,
  output logic timer1_irq
);

  // true when the prescaler has reached the end of one source period
  function automatic logic tick_hit(input logic [1:0] sel,
                                    input logic [`TCW_PRE_W-1:0] pre);
    logic [`TCW_PRE_W-1:0] mask;
    case (sel)
      `TCW_SRC_SLOW: mask = `TCW_MASK_SLOW;
      `TCW_SRC_MID: mask = `TCW_MASK_MID;
      `TCW_SRC_FAST: mask = `TCW_MASK_FAST;
      default: mask = `TCW_MASK_FULL;
    endcase
    return (pre & mask) == mask;
  endfunction : tick_hit

  // counter step, kept at full width
  function automatic logic [`TCW_CNT_W-1:0] bump(input logic [`TCW_CNT_W-1:0] v);
    return `TCW_CNT_W'(v + `TCW_CNT_ONE);
  endfunction : bump

  logic pin_s1;
  logic pin_s2;
  logic pin_prev;
  logic next_pin_s1;
  logic next_pin_s2;
  logic next_pin_prev;
  logic [`TCW_PRE_W-1:0] pre;
  logic [`TCW_PRE_W-1:0] next_pre;
  logic [1:0] next_start;
  logic [`TCW_CNT_W-1:0] next_count;
  logic [`TCW_CNT_W-1:0] next_capture_b;
  logic next_irq;
  tcw_pkg::tcw_phase_e phase;
  tcw_pkg::tcw_phase_e next_phase;
  logic running;
  logic src_tick;
  logic pin_rise;
  logic pin_fall;
  logic trig_edge;
  logic opp_edge;
  logic win_active;
  logic is_match;
  logic edge_cap;

  // pin is asynchronous: two flops, then a third for edge history
  always_comb begin
    next_pin_s1 = event_input_pin;
    next_pin_s2 = pin_s1;
    next_pin_prev = pin_s2;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_prev <= 1'b0;
    end else if (clock_enable) begin
      pin_s1 <= next_pin_s1;
      pin_s2 <= next_pin_s2;
      pin_prev <= next_pin_prev;
    end
  end

  // edges seen on the synchronised pin; level must last two cycles to be seen
  assign pin_rise = pin_s2 & ~pin_prev; // RULE4
  assign pin_fall = ~pin_s2 & pin_prev;
  assign running = start_edge_select != `TCW_START_STOP;
  // falling selected means falling is the count or trigger edge
  assign trig_edge = (start_edge_select == `TCW_START_FALL) ? pin_fall : pin_rise; // RULE1
  assign opp_edge = (start_edge_select == `TCW_START_FALL) ? pin_rise : pin_fall; // RULE3
  // negative logic counts while the window is low
  assign win_active = window_polarity ? ~pin_s2 : pin_s2; // RULE9
  assign is_match = count == compare_a;
  assign src_tick = tick_hit(source_clock_select, pre);

  // free running prescaler; it keeps running when stopped, so the first
  // tick after start may come early by up to one source period
  always_comb begin
    next_pre = `TCW_PRE_W'(pre + `TCW_PRE_ONE);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pre <= `TCW_PRE_ZERO;
    end else if (clock_enable) begin
      pre <= next_pre;
    end
  end

  // start field: power-down entry wins over a software write
  always_comb begin
    next_start = start_edge_select;
    if (stop_mode_enter) begin
      next_start = `TCW_START_STOP; // RULE19
    end else if (start_write) begin
      next_start = start_wdata;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      start_edge_select <= `TCW_START_STOP;
    end else if (clock_enable) begin
      start_edge_select <= next_start;
    end
  end

  // edge captures of pulse width mode; they take priority over auto-capture
  always_comb begin
    edge_cap = 1'b0;
    if (running && mode == tcw_pkg::TCW_PULSE && phase == tcw_pkg::TCW_RUN) begin
      edge_cap = opp_edge | (trig_edge & ~capture_edge_mode); // RULE12
    end
  end

  // counter, phase, capture and interrupt
  always_comb begin
    next_count = count;
    next_phase = phase;
    next_capture_b = capture_b;
    next_irq = 1'b0;
    if (!running) begin
      next_count = `TCW_CNT_ZERO; // RULE19
      next_phase = tcw_pkg::TCW_WAIT;
    end else begin
      case (mode)
        tcw_pkg::TCW_EVENT: begin
          if (trig_edge) begin
            next_count = bump(count); // RULE1
          end else if (opp_edge && is_match) begin
            next_count = `TCW_CNT_ZERO; // RULE2
            next_irq = 1'b1; // RULE3
          end
        end
        tcw_pkg::TCW_WINDOW: begin
          if (src_tick && win_active) begin
            if (is_match) begin
              next_count = `TCW_CNT_ZERO; // RULE8
              next_irq = 1'b1;
            end else begin
              next_count = bump(count); // RULE8
            end
          end
        end
        tcw_pkg::TCW_PULSE: begin
          if (phase == tcw_pkg::TCW_WAIT) begin
            // the held value of one survives the restart
            if (trig_edge) begin
              next_phase = tcw_pkg::TCW_RUN; // RULE11
            end
          end else if (opp_edge) begin
            next_capture_b = count; // RULE20
            next_irq = 1'b1;
            if (capture_edge_mode) begin
              next_count = `TCW_CNT_ONE; // RULE15
              next_phase = tcw_pkg::TCW_WAIT; // RULE13
            end else if (src_tick) begin
              next_count = bump(count); // RULE14
            end
          end else if (trig_edge && !capture_edge_mode) begin
            next_capture_b = count; // RULE14
            next_irq = 1'b1;
            next_count = `TCW_CNT_ZERO;
          end else if (src_tick) begin
            next_count = bump(count); // RULE11
          end
        end
        default: begin
          next_count = count;
        end
      endcase
      // running copy on each source tick unless an edge capture is due
      if (auto_capture_en && src_tick && !edge_cap) begin
        next_capture_b = count; // RULE5
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count <= `TCW_CNT_ZERO;
      phase <= tcw_pkg::TCW_WAIT;
      capture_b <= `TCW_CNT_ZERO;
      timer1_irq <= 1'b0;
    end else if (clock_enable) begin
      count <= next_count;
      phase <= next_phase;
      capture_b <= next_capture_b;
      timer1_irq <= next_irq;
    end
  end

  // checks, all on the one clock
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_pw_live;
    clock_enable && running && mode == tcw_pkg::TCW_PULSE;
  endsequence

  sequence s_single_cap;
    s_pw_live ##0 phase == tcw_pkg::TCW_RUN && capture_edge_mode && opp_edge;
  endsequence

  sequence s_held_one;
    timer1_irq && count == `TCW_CNT_ONE && phase == tcw_pkg::TCW_WAIT;
  endsequence

  evt_count_a: assert property ( // RULE1
    clock_enable && running && mode == tcw_pkg::TCW_EVENT && trig_edge
    |=> count == bump($past(count)) && !timer1_irq)
    else $error("event count did not step on counting edge");

  evt_match_a: assert property ( // RULE3
    clock_enable && running && mode == tcw_pkg::TCW_EVENT && opp_edge
    && count == compare_a |=> timer1_irq && count == `TCW_CNT_ZERO)
    else $error("event match at opposite edge did not interrupt and clear");

  evt_irq_edge_a: assert property ( // RULE2
    clock_enable && running && mode == tcw_pkg::TCW_EVENT && !opp_edge
    |=> !timer1_irq)
    else $error("event interrupt without opposite edge");

  win_count_a: assert property ( // RULE8
    clock_enable && running && mode == tcw_pkg::TCW_WINDOW && src_tick
    && win_active && count != compare_a |=> count == bump($past(count)))
    else $error("window count did not step");

  win_gate_a: assert property ( // RULE9
    clock_enable && running && mode == tcw_pkg::TCW_WINDOW && !win_active
    |=> count == $past(count) && !timer1_irq)
    else $error("window counted outside the window");

  auto_cap_a: assert property ( // RULE5
    clock_enable && running && auto_capture_en && src_tick && !edge_cap
    |=> capture_b == $past(count))
    else $error("auto capture missed a source tick");

  pw_start_a: assert property ( // RULE11
    s_pw_live ##0 phase == tcw_pkg::TCW_WAIT && trig_edge
    |=> phase == tcw_pkg::TCW_RUN)
    else $error("pulse mode did not start on trigger edge");

  single_cap_a: assert property ( // RULE13
    s_single_cap |=> s_held_one ##0 capture_b == $past(count))
    else $error("single-edge capture wrong");

  single_hold_a: assert property ( // RULE15
    s_pw_live ##0 phase == tcw_pkg::TCW_WAIT && !trig_edge
    |=> count == $past(count))
    else $error("counter moved while waiting for trigger");

  double_cap_a: assert property ( // RULE14
    s_pw_live ##0 phase == tcw_pkg::TCW_RUN && !capture_edge_mode && trig_edge
    && !opp_edge |=> timer1_irq && count == `TCW_CNT_ZERO
    && capture_b == $past(count) && phase == tcw_pkg::TCW_RUN)
    else $error("double-edge trigger capture wrong");

  stop_clear_a: assert property ( // RULE19
    clock_enable && stop_mode_enter
    |=> start_edge_select == `TCW_START_STOP ##1 count == `TCW_CNT_ZERO)
    else $error("stop entry did not halt the timer");

endmodule : tcw_timer1

// >>> verification/tcw_pulse_src.sv
`timescale 1ns/1ns
// far-side pulse source; it always drives the pin, so no release level
module tcw_pulse_src (
  input wire logic clock,
  output logic pin
);
  initial begin
    pin = 1'b0;
  end
  // a level shorter than two cycles could be missed, so never drive one
  task automatic hold(input logic lvl, input int n);
    int k;
    k = (n < 2) ? 2 : n;
    @(posedge clock);
    #1 pin = lvl;
    repeat (k - 1) @(posedge clock);
  endtask : hold
endmodule : tcw_pulse_src

// >>> verification/testbench.sv
`timescale 1ns/1ns
`include "tcw_map.svh"
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, x); end end

module testbench;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic pin;
  tcw_pkg::tcw_mode_e mode = tcw_pkg::TCW_IDLE;
  logic [1:0] src = `TCW_SRC_FULL;
  logic pol = 1'b0;
  logic cap_mode = 1'b1;
  logic auto_en = 1'b0;
  logic [15:0] cmp = 16'h0002;
  logic start_write = 1'b0;
  logic [1:0] start_wdata = 2'b00;
  logic stop_enter = 1'b0;
  logic ce = 1'b1;
  logic [1:0] start_sel;
  logic [15:0] count;
  logic [15:0] capture_b;
  logic [15:0] last_cap;
  logic irq;
  logic [17:0] notes[$];
  logic [17:0] e;
  int mismatches = 0;
  int checked = 0;
  int seed = 93;
  int l;

  always #25 clock = ~clock;

  tcw_timer1 u_tcw_timer1 (.clock(clock), .reset_n(reset_n), .clock_enable(ce),
    .event_input_pin(pin), .mode(mode), .source_clock_select(src),
    .window_polarity(pol), .capture_edge_mode(cap_mode), .auto_capture_en(auto_en),
    .compare_a(cmp), .start_write(start_write), .start_wdata(start_wdata),
    .stop_mode_enter(stop_enter), .start_edge_select(start_sel), .count(count),
    .capture_b(capture_b), .timer1_irq(irq));
  tcw_pulse_src u_tcw_pulse_src (.clock(clock), .pin(pin));

  // irq results in order; kind 1 exact count, kind 2 capture step, 0 skip
  always @(posedge clock) begin
    if (irq === 1'b1) begin
      if (notes.size() == 0) `CHK(irq, 1'b0)
      else begin
        e = notes.pop_front();
        if (e[17:16] == 2'd1) `CHK(count, e[15:0])
        if (e[17:16] == 2'd2) `CHK(capture_b - last_cap, e[15:0])
      end
      last_cap = capture_b;
    end
  end

  task automatic px(input logic lvl, input int n);
    u_tcw_pulse_src.hold(lvl, n);
  endtask : px

  task automatic set_start(input logic [1:0] code);
    @(posedge clock);
    #1 start_write = 1'b1;
    start_wdata = code;
    @(posedge clock);
    #1 start_write = 1'b0;
  endtask : set_start

  task automatic note(input logic [1:0] kind, input logic [15:0] val);
    notes.push_back({kind, val});
  endtask : note

  // bounded wait for every expected irq
  task automatic drain(input string name);
    int k;
    k = 0;
    // leave off the edge so the caller's next input change is clean
    #1;
    while (notes.size() != 0 && k < 300) begin
      @(posedge clock);
      #1 k++;
    end
    if (notes.size() != 0) begin
      mismatches++;
      final_report();
    end else $display("test %s done", name);
  endtask : drain

  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // hang guard
  initial begin
    repeat (40000) @(posedge clock);
    mismatches++;
    final_report();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge clock);
    #1 reset_n = 1'b1;
    mode = tcw_pkg::TCW_EVENT;
    // both counting edges; match shows only on the opposite edge
    for (int c = 2; c < 4; c++) begin
      set_start(`TCW_START_STOP);
      px(c == 2 ? 1'b0 : 1'b1, 4);
      set_start(c[1:0]);
      repeat (2) begin
        px(c == 2, 4);
        px(c != 2, 4);
        px(c == 2, 4);
        note(2'd1, 16'h0000);
        px(c != 2, 8);
      end
    end
    drain("event");
    set_start(`TCW_START_STOP);
    cmp = 16'h00ff;
    auto_en = 1'b1;
    px(1'b0, 4);
    set_start(`TCW_START_RISE);
    repeat (3) begin
      px(1'b1, 4);
      px(1'b0, 4);
    end
    repeat (4) @(posedge clock);
    #1 `CHK(capture_b, 16'h0003)
    auto_en = 1'b0;
    // frozen enable: a pin pulse meanwhile must leave no trace
    ce = 1'b0;
    px(1'b1, 4);
    px(1'b0, 4);
    #1 `CHK(count, 16'h0003)
    ce = 1'b1;
    $display("test auto done");
    // stop entry wins over a start write in the same cycle
    @(posedge clock);
    #1 stop_enter = 1'b1;
    start_write = 1'b1;
    start_wdata = `TCW_START_FALL;
    @(posedge clock);
    #1 stop_enter = 1'b0;
    start_write = 1'b0;
    @(posedge clock);
    #1 `CHK(start_sel, `TCW_START_STOP)
    `CHK(count, 16'h0000)
    $display("test stop done");
    mode = tcw_pkg::TCW_WINDOW;
    src = `TCW_SRC_FAST;
    cmp = 16'h0003;
    // a 64-cycle window holds exactly eight ticks, so two matches
    for (int p = 0; p < 2; p++) begin
      set_start(`TCW_START_STOP);
      pol = p[0];
      px(p[0], 8);
      set_start(`TCW_START_RISE);
      note(2'd1, 16'h0000);
      note(2'd1, 16'h0000);
      px(~p[0], 64);
      px(p[0], 16);
    end
    // slow rates and the command start: pin low for n periods holds n ticks
    cmp = 16'h00ff;
    for (int r = 0; r < 2; r++) begin
      set_start(`TCW_START_STOP);
      src = r[1:0];
      set_start(`TCW_START_CMD);
      px(1'b0, r == 0 ? 2048 : 256);
      px(1'b1, 4);
      #1 `CHK(count, r == 0 ? 16'h0001 : 16'h0002)
    end
    drain("window");
    mode = tcw_pkg::TCW_PULSE;
    src = `TCW_SRC_FULL;
    set_start(`TCW_START_STOP);
    px(1'b0, 4);
    set_start(`TCW_START_RISE);
    l = 4 + ($random(seed) & 15);
    // same high width each time: later captures one above the first
    for (int i = 0; i < 4; i++) begin
      px(1'b1, l);
      note(i == 0 ? 2'd0 : 2'd2, i == 1 ? 16'h0001 : 16'h0000);
      px(1'b0, 4 + ($random(seed) & 15));
    end
    drain("single");
    cap_mode = 1'b0;
    set_start(`TCW_START_STOP);
    px(1'b0, 4);
    set_start(`TCW_START_RISE);
    // trigger capture sits the low width above the opposite capture
    for (int i = 0; i < 3; i++) begin
      px(1'b1, 4 + ($random(seed) & 15));
      note(2'd0, 16'h0000);
      l = 4 + ($random(seed) & 15);
      px(1'b0, l);
      note(2'd2, l[15:0]);
    end
    px(1'b1, 8);
    drain("double");
    final_report();
  end
endmodule : testbench
